// >>> verilog/cipc_pkg.sv
package cipc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam int unsigned     CIPC_ADDR_W   = 8;
    localparam logic [7:0]      CIPC_CFG_OFS  = 8'h00;
    localparam logic [7:0]      CIPC_STAT_OFS = 8'h04;
    localparam logic [7:0]      CIPC_MASK_OFS = 8'h08;
    localparam logic [7:0]      CIPC_PEND_OFS = 8'h0C;

    // ------------------------------------------------------------
    // sizes and field values
    // ------------------------------------------------------------
    localparam int unsigned     CIPC_NUM_SLOTS = 4;
    localparam int unsigned     CIPC_NUM_CHAN  = 4;
    localparam int unsigned     CIPC_SEL_W     = 2;
    localparam int unsigned     CIPC_CFG_W     = 11;
    localparam logic [2:0]      CIPC_LEVEL_OFF = 3'h0;
    localparam logic [2:0]      CIPC_LEVEL_NMI = 3'h7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] level;
        logic [1:0] sel_d;
        logic [1:0] sel_c;
        logic [1:0] sel_b;
        logic [1:0] sel_a;
    } cipc_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic [1:0] slot;
    } cipc_pend_t;

    typedef struct packed {
        logic       nmi;
        logic [2:0] ipl;
    } cipc_core_req_t;

    typedef enum logic [1:0] {
        CIPC_S_IDLE = 2'b01,
        CIPC_S_RESP = 2'b10
    } cipc_apb_st_t;

    typedef struct packed {
        cipc_apb_st_t   fsm;
        cipc_cfg_t      cfg;
        logic [3:0]     status;
        logic [3:0]     mask;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
        logic           irq;
        cipc_core_req_t core;
        cipc_pend_t     pend;
    } cipc_state_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam cipc_cfg_t       CIPC_CFG_RST  = 11'h000;
    localparam logic [3:0]      CIPC_STAT_RST = 4'h0;
    localparam logic [3:0]      CIPC_MASK_RST = 4'h0;

endpackage

// >>> verilog/cipc_slot_mux.sv
`timescale 1ns/1ps
module cipc_slot_mux #(
    parameter int unsigned N_CHAN = 4,
    parameter int unsigned SEL_W  = 2
) (
    input  wire logic [SEL_W-1:0]  sel,
    input  wire logic [N_CHAN-1:0] req_in,
    output logic                   req_out
);

    // ------------------------------------------------------------
    // one slot: picks the request of the selected channel
    // ------------------------------------------------------------
    always_comb begin
        req_out = req_in[sel];
    end

endmodule

// >>> verilog/cipc_prio_enc.sv
`timescale 1ns/1ps
module cipc_prio_enc #(
    parameter int unsigned N     = 4,
    parameter int unsigned IDX_W = 2
) (
    input  wire logic [N-1:0]     pend,
    output logic                  valid,
    output logic [IDX_W-1:0]      idx
);

    // ------------------------------------------------------------
    // lowest index wins; slot a sits at index 0
    // ------------------------------------------------------------
    always_comb begin
        valid = |pend;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx = IDX_W'(i);
            end
        end
    end

endmodule

// >>> verilog/cipc_top.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module cipc_top (
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [7:0]               PADDR,
    input  wire logic [31:0]              PWDATA,
    input  wire logic [3:0]               PSTRB,
    input  wire logic [3:0]               CHAN_REQ,
    output logic                          PREADY,
    output logic [31:0]                   PRDATA,
    output logic                          PSLVERR,
    output logic                          IRQ,
    output cipc_pkg::cipc_core_req_t      CORE_REQ
);
    import cipc_pkg::*;

    cipc_state_t                          st;
    cipc_state_t                          next_st;
    logic [CIPC_NUM_SLOTS-1:0][1:0]       sel_vec;
    logic [CIPC_NUM_SLOTS-1:0]            slot_req;
    logic [CIPC_NUM_SLOTS-1:0]            eff_pend;
    logic                                 enc_valid;
    logic [1:0]                           enc_idx;
    logic                                 access;
    logic                                 done;
    logic                                 hit;
    logic                                 active;
    logic [31:0]                          rdata;
    cipc_cfg_t                            cfg_wr;

    // ------------------------------------------------------------
    // slot routing
    // ------------------------------------------------------------
    // selectors are read live, so a rewrite moves the routing on the next edge
    assign sel_vec = {st.cfg.sel_d, st.cfg.sel_c, st.cfg.sel_b, st.cfg.sel_a};

    for (genvar s = 0; s < CIPC_NUM_SLOTS; s++) begin : g_slot
        cipc_slot_mux #(
            .N_CHAN (CIPC_NUM_CHAN),
            .SEL_W  (CIPC_SEL_W)
        ) u_mux (
            .sel     (sel_vec[s]),
            .req_in  (CHAN_REQ),
            .req_out (slot_req[s])
        );
    end

    assign eff_pend = st.status & st.mask;

    cipc_prio_enc #(
        .N     (CIPC_NUM_SLOTS),
        .IDX_W (CIPC_SEL_W)
    ) u_prio (
        .pend  (eff_pend),
        .valid (enc_valid),
        .idx   (enc_idx)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign access = PSEL & PENABLE;
    assign done   = access & st.pready;
    assign hit    = (PADDR == CIPC_CFG_OFS) || (PADDR == CIPC_STAT_OFS) ||
                    (PADDR == CIPC_MASK_OFS) || (PADDR == CIPC_PEND_OFS);
    // no interrupt reaches the core while the level is zero
    assign active = enc_valid && (st.cfg.level != CIPC_LEVEL_OFF);

    always_comb begin
        unique case (PADDR)
            CIPC_CFG_OFS:  rdata = {21'h000000, st.cfg};
            CIPC_STAT_OFS: rdata = {28'h0000000, st.status};
            CIPC_MASK_OFS: rdata = {28'h0000000, st.mask};
            CIPC_PEND_OFS: rdata = {27'h0000000, st.pend};
            default:       rdata = 32'h00000000;
        endcase
    end

    always_comb begin
        cfg_wr = st.cfg;
        if (PSTRB[0]) begin
            cfg_wr[7:0] = PWDATA[7:0];
        end
        if (PSTRB[1]) begin
            cfg_wr[CIPC_CFG_W-1:8] = PWDATA[CIPC_CFG_W-1:8];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        unique case (st.fsm)
            CIPC_S_IDLE: begin
                if (access) begin
                    next_st.fsm     = CIPC_S_RESP;
                    next_st.pready  = 1'b1;
                    next_st.pslverr = !hit;
                    next_st.prdata  = PWRITE ? 32'h00000000 : rdata;
                end
            end
            CIPC_S_RESP: begin
                next_st.fsm     = CIPC_S_IDLE;
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
                next_st.prdata  = 32'h00000000;
            end
            default: begin
                next_st.fsm     = CIPC_S_IDLE;
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
                next_st.prdata  = 32'h00000000;
            end
        endcase

        // writes land only on the completing edge
        if (done && PWRITE && (PADDR == CIPC_CFG_OFS)) begin
            next_st.cfg = cfg_wr;
        end
        if (done && PWRITE && (PADDR == CIPC_MASK_OFS) && PSTRB[0]) begin
            next_st.mask = PWDATA[3:0];
        end

        // sticky status: a new request beats a write-one clear in the same cycle
        if (done && PWRITE && (PADDR == CIPC_STAT_OFS) && PSTRB[0]) begin
            next_st.status = (st.status & ~PWDATA[3:0]) | slot_req;
        end else begin
            next_st.status = st.status | slot_req;
        end

        next_st.irq      = active;
        next_st.core.ipl = active ? st.cfg.level : CIPC_LEVEL_OFF;
        next_st.core.nmi = active && (st.cfg.level == CIPC_LEVEL_NMI);
        next_st.pend     = '{valid: enc_valid, chan: sel_vec[enc_idx], slot: enc_idx};
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st.fsm     <= CIPC_S_IDLE;
            st.cfg     <= CIPC_CFG_RST;
            st.status  <= CIPC_STAT_RST;
            st.mask    <= CIPC_MASK_RST;
            st.pready  <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata  <= 32'h00000000;
            st.irq     <= 1'b0;
            st.core    <= 4'h0;
            st.pend    <= 5'h00;
        end else begin
            st <= next_st;
        end
    end

    assign PREADY   = st.pready;
    assign PRDATA   = st.prdata;
    assign PSLVERR  = st.pslverr;
    assign IRQ      = st.irq;
    assign CORE_REQ = st.core;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_slot_c_route: assert property (@(posedge CLK) disable iff (SYS_RST)
        CHAN_REQ[st.cfg.sel_c] |=> st.status[2])
        else $error("slot c selected channel not recorded");

    chk_slot_b_route: assert property (@(posedge CLK) disable iff (SYS_RST)
        CHAN_REQ[st.cfg.sel_b] |=> st.status[1])
        else $error("slot b selected channel not recorded");

    chk_slot_a_route: assert property (@(posedge CLK) disable iff (SYS_RST)
        CHAN_REQ[st.cfg.sel_a] |=> st.status[0])
        else $error("slot a selected channel not recorded");

    chk_cfg_live_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        (done && PWRITE && PADDR == CIPC_CFG_OFS && PSTRB[0])
        |=> st.cfg.sel_a == $past(PWDATA[1:0]))
        else $error("selector write did not take effect");

    chk_nmi_level: assert property (@(posedge CLK) disable iff (SYS_RST)
        (enc_valid && st.cfg.level == CIPC_LEVEL_NMI) |=> CORE_REQ.nmi && CORE_REQ.ipl == 3'h7)
        else $error("level 7 request not nonmaskable");

    chk_level_zero_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (st.cfg.level == CIPC_LEVEL_OFF) |=> (CORE_REQ.ipl == 3'h0 && !IRQ && !CORE_REQ.nmi))
        else $error("interrupt presented while level is zero");

    chk_reset_level: assert property (@(posedge CLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> (st.cfg.level == 3'h0 && CORE_REQ.ipl == 3'h0))
        else $error("level not cleared by reset");

    chk_prio_order: assert property (@(posedge CLK) disable iff (SYS_RST)
        (eff_pend[0] || eff_pend == 4'b1100) |=> st.pend.slot == ($past(eff_pend[0]) ? 2'h0 : 2'h2))
        else $error("pending slot order wrong");

    chk_apb_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
        (access && !st.pready) |=> PREADY ##1 !PREADY)
        else $error("apb answer timing wrong");

    chk_level_pass: assert property (@(posedge CLK) disable iff (SYS_RST)
        (enc_valid && st.cfg.level != CIPC_LEVEL_OFF) |=> CORE_REQ.ipl == $past(st.cfg.level))
        else $error("core level differs from programmed level");

    cov_nmi: cover property (@(posedge CLK) disable iff (SYS_RST) CORE_REQ.nmi);
    cov_two_pending: cover property (@(posedge CLK) disable iff (SYS_RST)
        $countones(eff_pend) > 1);
    cov_clear_vs_set: cover property (@(posedge CLK) disable iff (SYS_RST)
        done && PWRITE && PADDR == CIPC_STAT_OFS && |(PWDATA[3:0] & slot_req));
    cov_unmapped: cover property (@(posedge CLK) disable iff (SYS_RST) PSLVERR);

endmodule

// >>> tb/cipc_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// core side: takes the request level presented by the block
// ------------------------------------------------------------
module cipc_core_model (
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     IRQ,
    input  wire cipc_pkg::cipc_core_req_t CORE_REQ,
    output logic [2:0]                    taken_level,
    output logic                          taken_nmi
);
    import cipc_pkg::*;

    // no external pin, timer or watchdog of this core uses the level
    // one core per block, so levels never collide on a shared bus
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            taken_level <= 3'h0;
            taken_nmi   <= 1'b0;
        end else begin
            taken_level <= IRQ ? CORE_REQ.ipl : 3'h0;
            taken_nmi   <= IRQ & CORE_REQ.nmi;
        end
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cipc_pkg::*;

    logic           CLK = 1'b0;
    logic           SYS_RST = 1'b1;
    logic           PSEL = 1'b0;
    logic           PENABLE = 1'b0;
    logic           PWRITE = 1'b0;
    logic [7:0]     PADDR = 8'h00;
    logic [31:0]    PWDATA = 32'h0;
    logic [3:0]     PSTRB = 4'h0;
    logic [3:0]     CHAN_REQ = 4'h0;
    logic           PREADY;
    logic [31:0]    PRDATA;
    logic           PSLVERR;
    logic           IRQ;
    cipc_core_req_t CORE_REQ;
    logic [2:0]     taken_level;
    logic           taken_nmi;
    int             miscompares = 0;
    int             n_checks = 0;
    int             cycles = 0;
    logic [31:0]    rnd = 32'h22B15895;
    logic [31:0]    rd;
    logic           err;
    int             s;
    int             m;
    logic [3:0]     strb = 4'hF;

    cipc_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .CHAN_REQ(CHAN_REQ), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .IRQ(IRQ), .CORE_REQ(CORE_REQ));
    cipc_core_model core (.CLK(CLK), .SYS_RST(SYS_RST), .IRQ(IRQ), .CORE_REQ(CORE_REQ),
        .taken_level(taken_level), .taken_nmi(taken_nmi));

    initial begin
        forever #2.5 CLK = ~CLK;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // waits on pready with no cycle count assumed; the global timeout cuts a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        PSTRB   <= strb;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] req);
        @(posedge CLK);
        CHAN_REQ <= req;
        @(posedge CLK);
        CHAN_REQ <= 4'h0;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        apb(1'b0, CIPC_CFG_OFS, 32'h0);
        check("cfg_rst", rd, 32'h0);
        check("irq_rst", {31'h0, IRQ}, 32'h0);
        check("core_rst", {28'h0, CORE_REQ}, 32'h0);
        apb(1'b1, CIPC_MASK_OFS, 32'hF);
        // the four rotations put every code into every slot, rewritten live
        for (int r = 0; r < 4; r++) begin
            for (int ch = 0; ch < 4; ch++) begin
                apb(1'b1, CIPC_CFG_OFS, 32'h400 | r | (((r + 1) % 4) << 2)
                    | (((r + 2) % 4) << 4) | (((r + 3) % 4) << 6));
                apb(1'b1, CIPC_STAT_OFS, 32'hF);
                pulse(4'h1 << ch);
                s = (ch - r + 4) % 4;
                apb(1'b0, CIPC_STAT_OFS, 32'h0);
                check("slot_status", rd, 32'h1 << s);
                apb(1'b0, CIPC_PEND_OFS, 32'h0);
                check("pend", rd, 32'h10 | (ch << 2) | s);
                check("core_lvl4", {28'h0, CORE_REQ}, 32'h4);
            end
        end
        // level sweep with a pending slot
        for (int lvl = 0; lvl < 8; lvl++) begin
            apb(1'b1, CIPC_CFG_OFS, (lvl << 8) | 32'hE4);
            repeat (3) @(posedge CLK);
            check("irq_lvl", {31'h0, IRQ}, lvl != 0);
            check("core_lvl", {28'h0, CORE_REQ}, ((lvl == 7) << 3) | lvl);
            check("taken", {28'h0, taken_nmi, taken_level}, ((lvl == 7) << 3) | lvl);
        end
        // mid-run reset must drop the programmed level again
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        apb(1'b0, CIPC_CFG_OFS, 32'h0);
        check("cfg_rst2", rd, 32'h0);
        check("core_rst2", {28'h0, CORE_REQ}, 32'h0);
        // random requests and masks against slot priority
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, CIPC_CFG_OFS, 32'h4E4);
            apb(1'b1, CIPC_MASK_OFS, {28'h0, rnd[3:0]});
            apb(1'b1, CIPC_STAT_OFS, 32'hF);
            pulse(rnd[7:4]);
            m = rnd[3:0] & rnd[7:4];
            s = 0;
            while (m != 0 && !m[s]) s++;
            apb(1'b0, CIPC_PEND_OFS, 32'h0);
            check("prio", rd, (m != 0) ? (32'h10 | (s << 2) | s) : 32'h0);
            check("irq_mask", {31'h0, IRQ}, m != 0);
        end
        // low lane only: selectors move, level must stay
        strb = 4'h1;
        apb(1'b1, CIPC_CFG_OFS, 32'h71B);
        strb = 4'hF;
        apb(1'b0, CIPC_CFG_OFS, 32'h0);
        check("cfg_lane0", rd, 32'h41B);
        apb(1'b1, 8'h10, 32'hFFFF);
        check("unmapped_err", {31'h0, err}, 32'h1);
        final_report();
    end
endmodule
